// *** rtl/one_line_mode_port_config.sv ***
// Notes on behaviour
// R01 - Config one: 8 DAC, 6 ADC, 2 receiver channels
// R02 - Only config one gives 24-bit at 48 kHz
// R03 - Both rate fields equal; frame clocks identical
// R04 - Select 00: ADC on converter, receiver on host
// R05 - Software uses only valid config-one combinations
// R06 - Config one: device masters both ports
// R07 - Config one: external ADC clocked by host port
// R08 - No one-line: both bit clocks 64 Fs, any speed
// R09 - Config one mode 1: converter 128, host 64
// R10 - Config one ADC mode 2: converter 256, single
// R11 - Config two: no receiver data, 20-bit at 96 kHz
// R12 - Select 10: ADC data on host port only
// R13 - Config two: DAC one-line field only 00/01
// R14 - Config two: both masters, external ADC on converter
// R15 - Config two ADC mode 1: host 128, converter 64; with DAC mode 1 the code gives converter 128
// R16 - Config two DAC mode 1: converter 128, single
// R17 - Config two ADC mode 2: host 256, single only
// R18 - Speed classes: single, double, quad frame rates
// R19 - External ADC lines: left-justified 24-bit, 64/128 Fs
// R20 - Host processor is slave on both ports
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "olm_port_defines.svh"

module one_line_mode_port_config
    import olm_port_pkg::*;
#(
    parameter int SAMPLE_W = `SAMPLE_BITS,
    parameter int FRAME_SS = `FRAME_CYC_SS
) (
    input  wire logic                mclk_i,
    input  wire logic                reset_n_i,
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [7:0]          reg_wdata_i,
    input  wire logic                reg_write_i,
    input  wire logic                reg_read_i,
    output logic      [7:0]          reg_rdata_o,
    input  wire logic [SAMPLE_W-1:0] adc_left_i,
    input  wire logic [SAMPLE_W-1:0] adc_right_i,
    input  wire logic [SAMPLE_W-1:0] dai_left_i,
    input  wire logic [SAMPLE_W-1:0] dai_right_i,
    input  wire logic                external_adc_input_a_i,
    input  wire logic                external_adc_input_b_i,
    output logic                     converter_port_bit_clock_o,
    output logic                     converter_port_frame_clock_o,
    output logic                     host_port_bit_clock_o,
    output logic                     host_port_frame_clock_o,
    output logic                     converter_port_serial_out_o,
    output logic                     host_port_serial_out_o,
    output logic      [SAMPLE_W-1:0] ext_adc_a_o,
    output logic      [SAMPLE_W-1:0] ext_adc_b_o,
    output logic                     config_valid_o
);

    logic [7:0]  functional_mode_control;
    logic [7:0]  interface_format_control;
    logic [7:0]  miscellaneous_control;
    logic [1:0]  converter_port_rate_field;
    logic [1:0]  host_port_rate_field;
    logic [1:0]  adc_port_select_field;
    logic [1:0]  adc_one_line_field;
    logic [1:0]  dac_one_line_field;
    logic        converter_port_master_bit;
    logic        host_port_master_bit;
    logic        external_adc_clock_select;
    speed_t      speed;
    ratio_t      conv_ratio;
    ratio_t      host_ratio;
    src_t        conv_src;
    src_t        host_src;
    logic [2:0]  speed_mask;
    logic        cfg_ok;
    logic        cfg_write;
    logic        run;
    logic [7:0]  conv_half;
    logic [7:0]  host_half;
    logic [11:0] frame_cyc;
    logic [1:0]  port_fall;
    logic [1:0]  port_fedge;
    logic [1:0]  port_fclk;
    logic [1:0]  port_sout;
    src_t        port_src [2];
    logic [1:0]  ext_meta;
    logic [1:0]  ext_sync;
    logic [4:0]  cap_cnt;
    logic [SAMPLE_W-1:0] ext_shift [2];
    logic [SAMPLE_W-1:0] ext_word  [2];

    assign converter_port_rate_field = functional_mode_control[`CONV_RATE_LSB +: 2];
    assign host_port_rate_field      = functional_mode_control[`HOST_RATE_LSB +: 2];
    assign adc_port_select_field     = functional_mode_control[`ADC_SEL_LSB +: 2];
    assign adc_one_line_field        = interface_format_control[`ADC_OL_LSB +: 2];
    assign dac_one_line_field        = interface_format_control[`DAC_OL_LSB +: 2];
    assign converter_port_master_bit = miscellaneous_control[`CONV_MASTER_BIT];
    assign host_port_master_bit      = miscellaneous_control[`HOST_MASTER_BIT];
    assign external_adc_clock_select = miscellaneous_control[`EXT_ADC_CLK_BIT];
    assign speed     = speed_t'(converter_port_rate_field); // see R18
    assign cfg_write = reg_write_i && (reg_addr_i == `REG_FUNC_MODE ||
                       reg_addr_i == `REG_IFACE_FORMAT || reg_addr_i == `REG_MISC_CTRL);

    // Register writes
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            functional_mode_control  <= `FUNC_MODE_RESET;
            interface_format_control <= `IFACE_FORMAT_RESET;
            miscellaneous_control    <= `MISC_CTRL_RESET;
        end
        else if (reg_write_i)
        begin
            case (reg_addr_i)
                `REG_FUNC_MODE:    functional_mode_control  <= reg_wdata_i;
                `REG_IFACE_FORMAT: interface_format_control <= reg_wdata_i;
                `REG_MISC_CTRL:    miscellaneous_control    <= reg_wdata_i;
                default:           ;
            endcase
        end
    end

    // Register reads, data in the following cycle only
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i || !reg_read_i)
            reg_rdata_o <= 8'h00;
        else
        begin
            case (reg_addr_i)
                `REG_FUNC_MODE:    reg_rdata_o <= functional_mode_control;
                `REG_IFACE_FORMAT: reg_rdata_o <= interface_format_control;
                `REG_MISC_CTRL:    reg_rdata_o <= miscellaneous_control;
                `REG_PORT_STATUS:  reg_rdata_o <= {run, 1'b0, conv_ratio, host_ratio, speed};
                default:           reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Clocking matrix: ratios, allowed speeds and data routing per setup
    always_comb
    begin
        conv_ratio = RATIO_64;
        host_ratio = RATIO_64;
        speed_mask = 3'b000;
        conv_src   = SRC_NONE;
        host_src   = SRC_NONE;
        case (adc_port_select_field)
            2'b00:
            begin
                conv_src = SRC_ADC; // see R04, R01
                host_src = SRC_DAI; // see R04
                case ({adc_one_line_field, dac_one_line_field})
                    4'b0000: speed_mask = 3'b111; // see R08
                    4'b0001, 4'b0100, 4'b0101:
                    begin
                        conv_ratio = RATIO_128; // see R09
                        speed_mask = 3'b011;
                    end
                    4'b1000, 4'b1010:
                    begin
                        conv_ratio = RATIO_256; // see R10, R02
                        speed_mask = 3'b001;
                    end
                    default: speed_mask = 3'b000; // see R10, R05
                endcase
            end
            2'b10:
            begin
                host_src = SRC_ADC; // see R12, R11
                case ({adc_one_line_field, dac_one_line_field})
                    4'b0000: speed_mask = 3'b111; // see R08
                    4'b0100:
                    begin
                        host_ratio = RATIO_128; // see R15
                        speed_mask = 3'b011;
                    end
                    4'b0001:
                    begin
                        conv_ratio = RATIO_128; // see R16
                        speed_mask = 3'b001;
                    end
                    4'b0101:
                    begin
                        conv_ratio = RATIO_128; // see R16
                        host_ratio = RATIO_128;
                        speed_mask = 3'b001;
                    end
                    4'b1000:
                    begin
                        host_ratio = RATIO_256; // see R17
                        speed_mask = 3'b001;
                    end
                    default: speed_mask = 3'b000; // see R17, R13
                endcase
            end
            default: speed_mask = 3'b000;
        endcase
        cfg_ok = (speed != SPEED_NONE) && speed_mask[speed]
              && (converter_port_rate_field == host_port_rate_field) // see R03
              && converter_port_master_bit && host_port_master_bit // see R06, R14, R20
              && (external_adc_clock_select == adc_port_select_field[1]); // see R07, R14
    end

    // A configuration write restarts both ports so framing never glitches
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            run            <= 1'b0;
            config_valid_o <= 1'b0;
            conv_half      <= 8'h01;
            host_half      <= 8'h01;
        end
        else
        begin
            run            <= cfg_ok && !cfg_write;
            config_valid_o <= cfg_ok;
            conv_half      <= 8'(frame_cyc >> (7 + conv_ratio));
            host_half      <= 8'(frame_cyc >> (7 + host_ratio));
        end
    end

    assign frame_cyc = 12'(FRAME_SS >> speed); // see R18

    port_clock_gen #(.HALF_W(8), .BIT_W(9)) u_conv_clk (
        .mclk_i          (mclk_i),
        .reset_n_i       (reset_n_i),
        .run_i           (run),
        .half_i          (conv_half),
        .bits_per_half_i (9'(32 << conv_ratio)),
        .bit_clock_o     (converter_port_bit_clock_o),
        .frame_clock_o   (converter_port_frame_clock_o),
        .fall_o          (port_fall[0]),
        .frame_edge_o    (port_fedge[0])
    );

    port_clock_gen #(.HALF_W(8), .BIT_W(9)) u_host_clk (
        .mclk_i          (mclk_i),
        .reset_n_i       (reset_n_i),
        .run_i           (run),
        .half_i          (host_half),
        .bits_per_half_i (9'(32 << host_ratio)),
        .bit_clock_o     (host_port_bit_clock_o),
        .frame_clock_o   (host_port_frame_clock_o),
        .fall_o          (port_fall[1]),
        .frame_edge_o    (port_fedge[1])
    );

    assign port_fclk   = {host_port_frame_clock_o, converter_port_frame_clock_o};
    assign port_src[0] = conv_src;
    assign port_src[1] = host_src;

    // Left-justified serialisers, MSB first, new word at each frame edge
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_ser
            logic [SAMPLE_W-1:0] sreg;
            logic [SAMPLE_W-1:0] word;
            always_comb
            begin
                case (port_src[gi])
                    SRC_ADC: word = port_fclk[gi] ? adc_left_i : adc_right_i;
                    SRC_DAI: word = port_fclk[gi] ? dai_left_i : dai_right_i;
                    default: word = '0;
                endcase
            end
            always_ff @(posedge mclk_i)
            begin
                if (!reset_n_i || !run)
                begin
                    sreg          <= '0;
                    port_sout[gi] <= 1'b0;
                end
                else if (port_fedge[gi])
                begin
                    sreg          <= {word[SAMPLE_W-2:0], 1'b0};
                    port_sout[gi] <= word[SAMPLE_W-1];
                end
                else if (port_fall[gi])
                begin
                    sreg          <= {sreg[SAMPLE_W-2:0], 1'b0};
                    port_sout[gi] <= sreg[SAMPLE_W-1];
                end
            end
        end
    endgenerate

    assign converter_port_serial_out_o = port_sout[0];
    assign host_port_serial_out_o      = port_sout[1];

    // External ADC lines: two-flop synchronisers
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            ext_meta <= 2'b00;
            ext_sync <= 2'b00;
        end
        else
        begin
            ext_meta <= {external_adc_input_b_i, external_adc_input_a_i};
            ext_sync <= ext_meta;
        end
    end

    // Bit count since the selected port's frame edge; quad speed not captured
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i || !run || speed == SPEED_QUAD) // see R19
            cap_cnt <= 5'h00;
        else if (port_fedge[~external_adc_clock_select]) // see R07, R14
            cap_cnt <= 5'h00;
        else if (port_fall[~external_adc_clock_select] && cap_cnt < 5'(SAMPLE_W))
            cap_cnt <= cap_cnt + 5'h01;
    end

    // Sampling on the falling pulse sees the pin as it stood at the rising edge
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_ext
            always_ff @(posedge mclk_i)
            begin
                if (!reset_n_i)
                begin
                    ext_shift[gi] <= '0;
                    ext_word[gi]  <= '0;
                end
                else if (run && speed != SPEED_QUAD && !port_fedge[~external_adc_clock_select]
                         && port_fall[~external_adc_clock_select]
                         && cap_cnt < 5'(SAMPLE_W)) // see R19
                begin
                    ext_shift[gi] <= {ext_shift[gi][SAMPLE_W-2:0], ext_sync[gi]};
                    if (cap_cnt == 5'(SAMPLE_W - 1))
                        ext_word[gi] <= {ext_shift[gi][SAMPLE_W-2:0], ext_sync[gi]};
                end
            end
        end
    endgenerate

    assign ext_adc_a_o = ext_word[0];
    assign ext_adc_b_o = ext_word[1];

    AST_RATE_MATCH: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R03
        run |-> $past(converter_port_rate_field) == $past(host_port_rate_field))
        else $error("ports running with unequal rate fields");
    AST_SEL00_ROUTE: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R04
        (run && adc_port_select_field == 2'b00 && port_fedge[0] && converter_port_frame_clock_o)
        |=> converter_port_serial_out_o == $past(adc_left_i[SAMPLE_W-1]))
        else $error("select 00 routing wrong");
    AST_SEL10_QUIET: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R12
        (adc_port_select_field == 2'b10 && !cfg_write)[*3] |-> !converter_port_serial_out_o)
        else $error("converter output active with select 10");
    AST_MASTERS: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R06
        $rose(converter_port_bit_clock_o) |-> $past(converter_port_master_bit, 2)
        && $past(host_port_master_bit, 2))
        else $error("port clock driven without master bits");
    AST_EXT_CLK: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R07
        cfg_ok |-> external_adc_clock_select == (adc_port_select_field == 2'b10))
        else $error("external ADC clock source wrong");
    AST_PLAIN_64: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R08
        (cfg_ok && adc_one_line_field == 2'b00 && dac_one_line_field == 2'b00)
        |=> conv_half == host_half)
        else $error("plain mode ratios differ");
    AST_CFG1_256: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R10
        (cfg_ok && adc_port_select_field == 2'b00 && adc_one_line_field == 2'b10)
        |-> speed == SPEED_SINGLE
            ##1 (conv_half == 8'(FRAME_SS >> 9) && host_half == 8'(FRAME_SS >> 7)))
        else $error("config one mode 2 clocking wrong");
    AST_CFG2_DAC2: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R13
        (adc_port_select_field == 2'b10 && dac_one_line_field == 2'b10) |-> !cfg_ok)
        else $error("config two accepted DAC mode 2");
    AST_IDLE_CLK: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R05
        !run |=> !converter_port_bit_clock_o && !host_port_bit_clock_o)
        else $error("bit clock running while idle");

endmodule // one_line_mode_port_config

`default_nettype wire

// *** include/olm_port_defines.svh ***
`ifndef OLM_PORT_DEFINES_SVH
`define OLM_PORT_DEFINES_SVH

// Register offsets
`define REG_FUNC_MODE        8'h03
`define REG_IFACE_FORMAT     8'h04
`define REG_MISC_CTRL        8'h05
`define REG_PORT_STATUS      8'h06

// Reset values
`define FUNC_MODE_RESET      8'h00
`define IFACE_FORMAT_RESET   8'h00
`define MISC_CTRL_RESET      8'h00

// functional_mode_control fields (2 bits each)
`define CONV_RATE_LSB        6
`define HOST_RATE_LSB        4
`define ADC_SEL_LSB          2

// interface_format_control fields (2 bits each)
`define SERIAL_FMT_LSB       6
`define DAC_OL_LSB           2
`define ADC_OL_LSB           0

// miscellaneous_control bits
`define CONV_MASTER_BIT      7
`define HOST_MASTER_BIT      6
`define EXT_ADC_CLK_BIT      5

// Port status fields
`define STAT_VALID_BIT       7
`define STAT_CONV_RATIO_LSB  4
`define STAT_HOST_RATIO_LSB  2
`define STAT_SPEED_LSB       0

// Timing: master clock cycles per frame in single speed
`define FRAME_CYC_SS         512
// Sample width on the serial lines
`define SAMPLE_BITS          24

`endif

// *** include/olm_port_pkg.sv ***
package olm_port_pkg;

    typedef enum logic [1:0] {SPEED_SINGLE, SPEED_DOUBLE, SPEED_QUAD, SPEED_NONE} speed_t;
    typedef enum logic [1:0] {RATIO_64, RATIO_128, RATIO_256, RATIO_OFF} ratio_t;
    typedef enum logic [1:0] {SRC_NONE, SRC_ADC, SRC_DAI} src_t;

endpackage

// *** rtl/port_clock_gen.sv ***
`timescale 1ns/100ps
`default_nettype none

module port_clock_gen #(
    parameter int HALF_W = 8,
    parameter int BIT_W  = 9
) (
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    input  wire logic              run_i,
    input  wire logic [HALF_W-1:0] half_i,
    input  wire logic [BIT_W-1:0]  bits_per_half_i,
    output logic                   bit_clock_o,
    output logic                   frame_clock_o,
    output logic                   fall_o,
    output logic                   frame_edge_o
);

    logic [HALF_W-1:0] half_cnt;
    logic [BIT_W-1:0]  bit_cnt;

    // Frame clock changes on the bit clock's falling edge, as a master must
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i || !run_i)
        begin
            half_cnt      <= '0;
            bit_cnt       <= '0;
            bit_clock_o   <= 1'b0;
            frame_clock_o <= 1'b0;
            fall_o        <= 1'b0;
            frame_edge_o  <= 1'b0;
        end
        else
        begin
            fall_o       <= 1'b0;
            frame_edge_o <= 1'b0;
            if (half_cnt == half_i - HALF_W'(1))
            begin
                half_cnt    <= '0;
                bit_clock_o <= ~bit_clock_o;
                if (bit_clock_o)
                begin
                    fall_o <= 1'b1;
                    if (bit_cnt == bits_per_half_i - BIT_W'(1))
                    begin
                        bit_cnt       <= '0;
                        frame_clock_o <= ~frame_clock_o;
                        frame_edge_o  <= 1'b1;
                    end
                    else
                    begin
                        bit_cnt <= bit_cnt + BIT_W'(1);
                    end
                end
            end
            else
            begin
                half_cnt <= half_cnt + HALF_W'(1);
            end
        end
    end

endmodule // port_clock_gen

`default_nettype wire

// *** verif/host_slave_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module host_slave_model (
    input  wire logic        bit_clock_i,
    input  wire logic        frame_clock_i,
    input  wire logic        serial_i,
    input  wire logic [23:0] ext_word_a_i,
    input  wire logic [23:0] ext_word_b_i,
    output logic      [31:0] left_word_o,
    output logic      [31:0] right_word_o,
    output logic             ext_a_o,
    output logic             ext_b_o
);
    logic [31:0] shift   = 32'h0;
    logic        lr_rise = 1'b0;
    logic        lr_fall = 1'b0;
    int          idx     = -1;

    initial
    begin
        left_word_o  = 32'h0;
        right_word_o = 32'h0;
        ext_a_o      = 1'b0;
        ext_b_o      = 1'b0;
    end

    // Slave only: takes the device's clocks, samples on the rising bit clock
    always @(posedge bit_clock_i)
    begin
        if (frame_clock_i != lr_rise)
        begin
            if (lr_rise)
                left_word_o <= shift;
            else
                right_word_o <= shift;
            shift <= {31'h0, serial_i};
        end
        else
            shift <= {shift[30:0], serial_i};
        lr_rise <= frame_clock_i;
    end

    // External converter: MSB at the frame edge, then a toggling line so no stale bit passes
    always @(negedge bit_clock_i)
    begin
        #1;
        if (frame_clock_i != lr_fall)
            idx = 23;
        lr_fall = frame_clock_i;
        ext_a_o = (idx >= 0) ? ext_word_a_i[idx] : ~ext_a_o;
        ext_b_o = (idx >= 0) ? ext_word_b_i[idx] : ~ext_b_o;
        idx = idx - 1;
    end
endmodule // host_slave_model

`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "olm_port_defines.svh"

module tb_top;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [23:0] adc_l = 24'h0, adc_r = 24'h0, dai_l = 24'h0, dai_r = 24'h0;
    logic [23:0] wa = 24'h0, wb = 24'h0;
    logic        ext_on_conv = 1'b0;
    int          seed = 56689;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cycles = 0;
    wire  [7:0]  rdata;
    wire  [23:0] ext_wa, ext_wb;
    wire  [31:0] c_left, c_right, h_left, h_right;
    wire         cbclk, clr, hbclk, hlr, csd, hsd, valid, c_ea, c_eb, h_ea, h_eb;
    wire         ext_a = ext_on_conv ? c_ea : h_ea;
    wire         ext_b = ext_on_conv ? c_eb : h_eb;

    // Entry {ok, conv ratio, host ratio, top speed}, indexed by {adc field, dac field}
    localparam logic [6:0] CFG_ONE [16] = '{7'h42, 7'h51, 7'h00, 7'h00, 7'h51, 7'h51,
        7'h00, 7'h00, 7'h60, 7'h00, 7'h60, 7'h00, 7'h00, 7'h00, 7'h00,
        7'h00};
    localparam logic [6:0] CFG_TWO [16] = '{7'h42, 7'h50, 7'h00, 7'h00, 7'h45, 7'h54,
        7'h00, 7'h00, 7'h48, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
        7'h00};

    one_line_mode_port_config one_line_mode_port_config_i (
        .mclk_i(mclk), .reset_n_i(reset_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata),
        .adc_left_i(adc_l), .adc_right_i(adc_r), .dai_left_i(dai_l), .dai_right_i(dai_r),
        .external_adc_input_a_i(ext_a), .external_adc_input_b_i(ext_b),
        .converter_port_bit_clock_o(cbclk), .converter_port_frame_clock_o(clr),
        .host_port_bit_clock_o(hbclk), .host_port_frame_clock_o(hlr),
        .converter_port_serial_out_o(csd), .host_port_serial_out_o(hsd),
        .ext_adc_a_o(ext_wa), .ext_adc_b_o(ext_wb), .config_valid_o(valid));

    host_slave_model conv_slave_i (.bit_clock_i(cbclk), .frame_clock_i(clr), .serial_i(csd),
        .ext_word_a_i(wa), .ext_word_b_i(wb), .left_word_o(c_left), .right_word_o(c_right),
        .ext_a_o(c_ea), .ext_b_o(c_eb));
    host_slave_model host_slave_i (.bit_clock_i(hbclk), .frame_clock_i(hlr), .serial_i(hsd),
        .ext_word_a_i(wa), .ext_word_b_i(wb), .left_word_o(h_left), .right_word_o(h_right),
        .ext_a_o(h_ea), .ext_b_o(h_eb));

    initial
    begin
        forever #20 mclk = ~mclk;
    end

    task automatic print_verdict();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask

    // Returns {valid, expected status}; rates must match, masters set, clock source follows select
    function automatic logic [8:0] expect_cfg(input logic [7:0] f, i, m);
        logic [6:0] e;
        e = (f[3:2] == 2'h0) ? CFG_ONE[{i[1:0], i[3:2]}] : CFG_TWO[{i[1:0], i[3:2]}];
        if (f[7:6] != f[5:4] || f[7:6] == 2'h3 || !m[7] || !m[6] || m[5] != f[3] || f[2]
            || f[7:6] > e[1:0])
            e[6] = 1'b0;
        return e[6] ? {2'b11, 1'b0, e[5:2], f[7:6]} : 9'h0;
    endfunction

    // Bit clock edges in 256 cycles: two per bit, ratio bits per frame
    function automatic logic [31:0] exp_edges(input logic [1:0] r, input logic [1:0] s);
        return 32'((128 << r) * 256 / (`FRAME_CYC_SS >> s));
    endfunction

    task automatic run_data(input logic [7:0] f, input logic [7:0] m);
        @(posedge mclk);
        adc_l <= 24'($random(seed));
        adc_r <= 24'($random(seed));
        dai_l <= 24'($random(seed));
        dai_r <= 24'($random(seed));
        wa    <= 24'($random(seed));
        wb    <= 24'($random(seed));
        ext_on_conv <= m[5];
        write_reg(`REG_FUNC_MODE, f);
        write_reg(`REG_IFACE_FORMAT, 8'h00);
        write_reg(`REG_MISC_CTRL, m);
        repeat (4 * `FRAME_CYC_SS) @(posedge mclk);
        @(negedge mclk);
        check(c_left, f[3] ? 32'h0 : {adc_l, 8'h00});
        check(c_right, f[3] ? 32'h0 : {adc_r, 8'h00});
        check(h_left, {f[3] ? adc_l : dai_l, 8'h00});
        check(h_right, {f[3] ? adc_r : dai_r, 8'h00});
        check(32'(ext_wa), 32'(wa));
        check(32'(ext_wb), 32'(wb));
        check(32'(clr), 32'(hlr));
    endtask

    initial
    begin
        logic [7:0] f, i, m, st;
        logic [8:0] e;
        int         tc, th;
        logic       pc, ph;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        for (int a = 3; a < 8; a++)
        begin
            read_reg(a[7:0], st);
            check(32'(st), 32'h0);
        end
        write_reg(`REG_IFACE_FORMAT, 8'hC0);
        read_reg(`REG_IFACE_FORMAT, st);
        check(32'(st), 32'hC0);
        @(negedge mclk);
        check(32'(rdata), 32'h0);
        for (int k = 0; k < 160; k++)
        begin
            f = {k[6:5], k[6:5], k[4], 3'h0};
            i = {4'h0, k[3:0]};
            m = {2'h3, k[4], 5'h0};
            if (k >= 128)
            begin
                {f, i, m} = 24'($random(seed));
                f[5:4] = k[0] ? f[7:6] : f[5:4];
                m[7:5] = k[1] ? {2'h3, f[3]} : m[7:5];
            end
            write_reg(`REG_FUNC_MODE, f);
            write_reg(`REG_IFACE_FORMAT, i);
            write_reg(`REG_MISC_CTRL, m);
            write_reg(`REG_PORT_STATUS, 8'h5A);
            repeat (4) @(posedge mclk);
            e = expect_cfg(f, i, m);
            read_reg(`REG_PORT_STATUS, st);
            check(32'(st & (e[8] ? 8'hFF : 8'h80)), 32'(e[7:0]));
            check(32'(valid), 32'(e[8]));
            if (!e[8])
                check(32'(cbclk | hbclk | csd | hsd), 32'h0);
            if (e[8])
            begin
                tc = 0;
                th = 0;
                repeat (256)
                begin
                    pc = cbclk;
                    ph = hbclk;
                    @(negedge mclk);
                    tc += int'(cbclk != pc);
                    th += int'(hbclk != ph);
                end
                check(32'(tc), exp_edges(e[5:4], f[7:6]));
                check(32'(th), exp_edges(e[3:2], f[7:6]));
            end
        end
        run_data(8'h00, 8'hC0);
        run_data(8'h08, 8'hE0);
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
